// [tcc_cfg.svh]
// register offsets, reset values and timing counts for the capture/compare
// Overview of operation
// R01: two 16-bit capture registers latch counter on edges
// R02: per-channel edge select bit; captures read-only
// R03: capture sets flag and loads counter value
// R04: one capture enable, pending until cpu mask clear
// R05: capture flag cleared by status read, low access
// R06: high byte read locks capture until low read
// R07: capture register holds most recent unlocked capture
// R08: special modes leave only capture channel two
// R09: capture pins always feed the timer
// R10: two 16-bit compare registers checked each tick
// R11: compare registers software-only, reset to 8000h
// R12: match sets flag, drives level, may interrupt
// R13: compare pin latch low during reset
// R14: output disabled: pin untouched, flag still works
// R15: compare flag cleared by status read, low access
// R16: high byte write inhibits compare until low write
// R17: divide-by-2 matches equal, others equal plus one
// R18: force bit copies level without flag or interrupt
// R19: force bits ignored in special modes
// R20: software writes high, reads status, writes low
// R21: capture and compare channels run concurrently
// R22: prescaler divides cpu clock by 2, 4, 8
// R23: counter resets FFFCh, overflow flag, reload on write
// R24: both select bits set picks external pin clock
// R25: all timer conditions merge into one interrupt
// R26: capture pins synchronised before edge detection
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH
`define TCC_ADDR_CTRL_ONE 8'h00
`define TCC_ADDR_CTRL_TWO 8'h01
`define TCC_ADDR_STATUS 8'h02
`define TCC_ADDR_CAP1_HI 8'h03
`define TCC_ADDR_CAP1_LO 8'h04
`define TCC_ADDR_CAP2_HI 8'h05
`define TCC_ADDR_CAP2_LO 8'h06
`define TCC_ADDR_CMP1_HI 8'h07
`define TCC_ADDR_CMP1_LO 8'h08
`define TCC_ADDR_CMP2_HI 8'h09
`define TCC_ADDR_CMP2_LO 8'h0a
`define TCC_ADDR_CNT_HI 8'h0b
`define TCC_ADDR_CNT_LO 8'h0c
`define TCC_ADDR_ALT_HI 8'h0d
`define TCC_ADDR_ALT_LO 8'h0e
`define TCC_CNT_RESET 16'hfffc
`define TCC_CNT_TOP 16'hffff
`define TCC_CMP_RESET 16'h8000
`define TCC_CTRL_RESET 8'h00
`define TCC_DIV2_LAST 3'h1
`define TCC_DIV4_LAST 3'h3
`define TCC_DIV8_LAST 3'h7
`endif

// [tcc_pkg.sv]
// types shared by the capture/compare unit
package tcc_pkg;
  typedef enum logic [1:0] {
    TCC_CLK_DIV4 = 2'b00,
    TCC_CLK_DIV2 = 2'b01,
    TCC_CLK_DIV8 = 2'b10,
    TCC_CLK_EXT = 2'b11
  } tcc_clk_sel_t;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic [1:0] force_level_bit;
    logic capture_edge_select_one;
    logic [1:0] compare_level_bit;
  } tcc_ctrl_one_t;

  typedef struct packed {
    logic [1:0] compare_output_enable;
    logic single_pulse_mode;
    logic pwm_mode;
    tcc_clk_sel_t timer_clock_select;
    logic capture_edge_select_two;
    logic ext_clock_edge;
  } tcc_ctrl_two_t;

  typedef struct packed {
    logic [1:0] capture_flag;
    logic [1:0] compare_flag;
    logic counter_overflow_flag;
    logic [2:0] reserved;
  } tcc_status_t;
endpackage : tcc_pkg

// [tcc_top.sv]
// capture/compare unit around a 16-bit free-running counter
`include "tcc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tcc_top (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // cpu interrupt mask, high blocks the request
  input wire logic i_cpu_mask,
  output logic o_timer_irq,
  // pins
  input wire logic [1:0] i_capture_pin,
  input wire logic i_ext_clk_pin,
  output logic [1:0] o_compare_output_pin,
  output logic [1:0] o_compare_output_oe
);

  function automatic logic tcc_edge(input logic cur, input logic prev,
                                    input logic rising);
    tcc_edge = rising ? (cur & ~prev) : (~cur & prev);
  endfunction : tcc_edge

  function automatic logic tcc_hit(input logic [15:0] cnt,
                                   input logic [15:0] val,
                                   input logic div2);
    logic [15:0] late;
    late = val + 16'h0001;
    tcc_hit = div2 ? (cnt == val) : (cnt == late);
  endfunction : tcc_hit

  tcc_pkg::tcc_ctrl_one_t ctrl_one_reg;
  tcc_pkg::tcc_ctrl_two_t ctrl_two_reg;
  tcc_pkg::tcc_ctrl_one_t wr_one;
  tcc_pkg::tcc_status_t status;
  logic [1:0] cap_sync1_reg;
  logic [1:0] cap_sync2_reg;
  logic [1:0] cap_prev_reg;
  logic ext_sync1_reg;
  logic ext_sync2_reg;
  logic ext_prev_reg;
  logic [2:0] presc_reg;
  logic tick;
  logic tick_d_reg;
  logic [15:0] cnt_reg;
  logic [7:0] cnt_buf_reg;
  logic cnt_seq_reg;
  logic [15:0] cap_val_reg [0:1];
  logic [15:0] cmp_val_reg [0:1];
  logic [1:0] cap_lock_reg;
  logic [1:0] cap_flag_reg;
  logic [1:0] cap_arm_reg;
  logic [1:0] cmp_inhibit_reg;
  logic [1:0] cmp_flag_reg;
  logic [1:0] cmp_arm_reg;
  logic ovf_flag_reg;
  logic ovf_arm_reg;
  logic [1:0] pin_reg;
  logic [7:0] rdata_reg;
  logic special_mode;
  logic status_rd;
  logic cnt_reload;
  logic ovf_evt;
  logic [1:0] edge_sel;
  logic [1:0] cap_evt;
  logic [1:0] cmp_hit;
  logic [1:0] cap_hi_rd;
  logic [1:0] cap_lo_rd;
  logic [1:0] cap_lo_acc;
  logic [1:0] cmp_hi_wr;
  logic [1:0] cmp_lo_wr;
  logic [1:0] cmp_lo_acc;
  logic [1:0] force_go;

  // address decode
  assign status_rd = i_rd && (i_addr == `TCC_ADDR_STATUS);
  assign cap_hi_rd[0] = i_rd && (i_addr == `TCC_ADDR_CAP1_HI);
  assign cap_hi_rd[1] = i_rd && (i_addr == `TCC_ADDR_CAP2_HI);
  assign cap_lo_rd[0] = i_rd && (i_addr == `TCC_ADDR_CAP1_LO);
  assign cap_lo_rd[1] = i_rd && (i_addr == `TCC_ADDR_CAP2_LO);
  assign cap_lo_acc[0] = (i_rd || i_wr) && (i_addr == `TCC_ADDR_CAP1_LO);
  assign cap_lo_acc[1] = (i_rd || i_wr) && (i_addr == `TCC_ADDR_CAP2_LO);
  assign cmp_hi_wr[0] = i_wr && (i_addr == `TCC_ADDR_CMP1_HI);
  assign cmp_hi_wr[1] = i_wr && (i_addr == `TCC_ADDR_CMP2_HI);
  assign cmp_lo_wr[0] = i_wr && (i_addr == `TCC_ADDR_CMP1_LO);
  assign cmp_lo_wr[1] = i_wr && (i_addr == `TCC_ADDR_CMP2_LO);
  assign cmp_lo_acc[0] = (i_rd || i_wr) && (i_addr == `TCC_ADDR_CMP1_LO);
  assign cmp_lo_acc[1] = (i_rd || i_wr) && (i_addr == `TCC_ADDR_CMP2_LO);
  assign cnt_reload = i_wr && ((i_addr == `TCC_ADDR_CNT_LO) ||
                               (i_addr == `TCC_ADDR_ALT_LO));

  assign special_mode = ctrl_two_reg.single_pulse_mode | ctrl_two_reg.pwm_mode;
  assign wr_one = tcc_pkg::tcc_ctrl_one_t'(i_wdata);

  // control registers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_one_reg <= tcc_pkg::tcc_ctrl_one_t'(`TCC_CTRL_RESET);
    end else if (i_wr && (i_addr == `TCC_ADDR_CTRL_ONE)) begin
      ctrl_one_reg <= wr_one;
      ctrl_one_reg.force_level_bit <= 2'h0; // force is a strobe, reads 0
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl_two_reg <= tcc_pkg::tcc_ctrl_two_t'(`TCC_CTRL_RESET);
    end else if (i_wr && (i_addr == `TCC_ADDR_CTRL_TWO)) begin
      ctrl_two_reg <= tcc_pkg::tcc_ctrl_two_t'(i_wdata);
    end
  end

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cap_sync1_reg <= 2'h0;
      cap_sync2_reg <= 2'h0;
      cap_prev_reg <= 2'h0;
      ext_sync1_reg <= 1'b0;
      ext_sync2_reg <= 1'b0;
      ext_prev_reg <= 1'b0;
    end else begin
      cap_sync1_reg <= i_capture_pin; // [R26] [R09]
      cap_sync2_reg <= cap_sync1_reg;
      cap_prev_reg <= cap_sync2_reg;
      ext_sync1_reg <= i_ext_clk_pin;
      ext_sync2_reg <= ext_sync1_reg;
      ext_prev_reg <= ext_sync2_reg;
    end
  end

  // prescaler and timer tick
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      presc_reg <= 3'h0;
    end else begin
      presc_reg <= presc_reg + 3'h1;
    end
  end

  always_comb begin
    case (ctrl_two_reg.timer_clock_select)
      tcc_pkg::TCC_CLK_DIV2: tick = (presc_reg[0] == 1'(`TCC_DIV2_LAST)); // [R22]
      tcc_pkg::TCC_CLK_DIV4: tick = (presc_reg[1:0] == 2'(`TCC_DIV4_LAST));
      tcc_pkg::TCC_CLK_DIV8: tick = (presc_reg == `TCC_DIV8_LAST);
      // sampled edge of the external clock, one count per selected edge [R24]
      default: tick = tcc_edge(ext_sync2_reg, ext_prev_reg,
                               ctrl_two_reg.ext_clock_edge);
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      tick_d_reg <= 1'b0;
    end else begin
      tick_d_reg <= tick;
    end
  end

  // free-running counter
  assign ovf_evt = tick && !cnt_reload && (cnt_reg == `TCC_CNT_TOP);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_reg <= `TCC_CNT_RESET; // [R23]
    end else if (cnt_reload) begin
      cnt_reg <= `TCC_CNT_RESET; // [R23]
    end else if (tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // low byte frozen from the first high read until the low read
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt_buf_reg <= 8'h00;
      cnt_seq_reg <= 1'b0;
    end else if (i_rd && ((i_addr == `TCC_ADDR_CNT_LO) ||
                          (i_addr == `TCC_ADDR_ALT_LO))) begin
      cnt_seq_reg <= 1'b0;
    end else if (i_rd && !cnt_seq_reg && ((i_addr == `TCC_ADDR_CNT_HI) ||
                                          (i_addr == `TCC_ADDR_ALT_HI))) begin
      cnt_buf_reg <= cnt_reg[7:0];
      cnt_seq_reg <= 1'b1;
    end
  end

  // overflow flag; set wins over clear
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovf_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end else if (ovf_evt) begin
      ovf_flag_reg <= 1'b1; // [R23]
    end else if (ovf_arm_reg && (i_rd || i_wr) &&
                 (i_addr == `TCC_ADDR_CNT_LO)) begin
      ovf_flag_reg <= 1'b0;
      ovf_arm_reg <= 1'b0;
    end else if (status_rd && ovf_flag_reg) begin
      ovf_arm_reg <= 1'b1;
    end
  end

  // capture channels
  assign edge_sel = {ctrl_two_reg.capture_edge_select_two,
                     ctrl_one_reg.capture_edge_select_one};

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cap_evt[i] = tcc_edge(cap_sync2_reg[i], cap_prev_reg[i],
                            edge_sel[i]) && !cap_lock_reg[i]; // [R02] [R06]
    end
    cap_evt[0] = cap_evt[0] && !special_mode; // [R08]
  end

  // both channels are independent of the compare side [R21]
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (i_rst) begin
        cap_val_reg[i] <= 16'h0000;
        cap_lock_reg[i] <= 1'b0;
      end else begin
        if (cap_evt[i]) begin
          cap_val_reg[i] <= cnt_reg; // [R01] [R03] [R07]
        end
        if (cap_lo_rd[i]) begin
          cap_lock_reg[i] <= 1'b0;
        end else if (cap_hi_rd[i]) begin
          cap_lock_reg[i] <= 1'b1; // [R06]
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (i_rst) begin
        cap_flag_reg[i] <= 1'b0;
        cap_arm_reg[i] <= 1'b0;
      end else if (cap_evt[i]) begin
        cap_flag_reg[i] <= 1'b1; // [R03]
      end else if (cap_arm_reg[i] && cap_lo_acc[i]) begin
        cap_flag_reg[i] <= 1'b0; // [R05]
        cap_arm_reg[i] <= 1'b0;
      end else if (status_rd && cap_flag_reg[i]) begin
        cap_arm_reg[i] <= 1'b1; // [R05]
      end
    end
  end

  // compare channels; the extra cycle on slow clocks matches the
  // latched compare of the original timer [R17]
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      cmp_hit[i] = tick_d_reg && !cmp_inhibit_reg[i] && // [R10] [R16]
                   tcc_hit(cnt_reg, cmp_val_reg[i],
                           ctrl_two_reg.timer_clock_select ==
                           tcc_pkg::TCC_CLK_DIV2); // [R17]
    end
  end

  // hardware never writes these [R11]
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (i_rst) begin
        cmp_val_reg[i] <= `TCC_CMP_RESET; // [R11]
        cmp_inhibit_reg[i] <= 1'b0;
      end else if (cmp_hi_wr[i]) begin
        cmp_val_reg[i][15:8] <= i_wdata;
        cmp_inhibit_reg[i] <= 1'b1; // [R16]
      end else if (cmp_lo_wr[i]) begin
        cmp_val_reg[i][7:0] <= i_wdata;
        cmp_inhibit_reg[i] <= 1'b0; // [R16]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (i_rst) begin
        cmp_flag_reg[i] <= 1'b0;
        cmp_arm_reg[i] <= 1'b0;
      end else if (cmp_hit[i]) begin
        cmp_flag_reg[i] <= 1'b1; // [R12] [R14]
      end else if (cmp_arm_reg[i] && cmp_lo_acc[i]) begin
        cmp_flag_reg[i] <= 1'b0; // [R15]
        cmp_arm_reg[i] <= 1'b0;
      end else if (status_rd && cmp_flag_reg[i]) begin
        cmp_arm_reg[i] <= 1'b1; // [R15]
      end
    end
  end

  // pin latch; force touches no flag [R18]
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      force_go[i] = i_wr && (i_addr == `TCC_ADDR_CTRL_ONE) &&
                    wr_one.force_level_bit[i] && !special_mode; // [R19]
    end
  end

  always_ff @(posedge i_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (i_rst) begin
        pin_reg[i] <= 1'b0; // [R13]
      end else if (!ctrl_two_reg.compare_output_enable[i]) begin
        pin_reg[i] <= pin_reg[i]; // [R14]
      end else if (force_go[i]) begin
        pin_reg[i] <= wr_one.compare_level_bit[i]; // [R18]
      end else if (cmp_hit[i]) begin
        pin_reg[i] <= ctrl_one_reg.compare_level_bit[i]; // [R12]
      end
    end
  end

  assign o_compare_output_pin = pin_reg;
  assign o_compare_output_oe = ctrl_two_reg.compare_output_enable;

  // one request line, pending until the cpu mask opens
  assign o_timer_irq = !i_cpu_mask && // [R04] [R25]
    ((|cap_flag_reg && ctrl_one_reg.capture_irq_enable) ||
     (|cmp_flag_reg && ctrl_one_reg.compare_irq_enable) || // [R12]
     (ovf_flag_reg && ctrl_one_reg.overflow_irq_enable));

  // read data, one cycle after the strobe
  always_comb begin
    status = '0;
    status.capture_flag = cap_flag_reg;
    status.compare_flag = cmp_flag_reg;
    status.counter_overflow_flag = ovf_flag_reg;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_reg <= 8'h00;
    end else if (!i_rd) begin
      rdata_reg <= 8'h00;
    end else if (i_addr == `TCC_ADDR_CTRL_ONE) begin
      rdata_reg <= ctrl_one_reg;
    end else if (i_addr == `TCC_ADDR_CTRL_TWO) begin
      rdata_reg <= ctrl_two_reg;
    end else if (i_addr == `TCC_ADDR_STATUS) begin
      rdata_reg <= status;
    end else if (i_addr == `TCC_ADDR_CAP1_HI) begin
      rdata_reg <= cap_val_reg[0][15:8];
    end else if (i_addr == `TCC_ADDR_CAP1_LO) begin
      rdata_reg <= cap_val_reg[0][7:0];
    end else if (i_addr == `TCC_ADDR_CAP2_HI) begin
      rdata_reg <= cap_val_reg[1][15:8];
    end else if (i_addr == `TCC_ADDR_CAP2_LO) begin
      rdata_reg <= cap_val_reg[1][7:0];
    end else if (i_addr == `TCC_ADDR_CMP1_HI) begin
      rdata_reg <= cmp_val_reg[0][15:8];
    end else if (i_addr == `TCC_ADDR_CMP1_LO) begin
      rdata_reg <= cmp_val_reg[0][7:0];
    end else if (i_addr == `TCC_ADDR_CMP2_HI) begin
      rdata_reg <= cmp_val_reg[1][15:8];
    end else if (i_addr == `TCC_ADDR_CMP2_LO) begin
      rdata_reg <= cmp_val_reg[1][7:0];
    end else if ((i_addr == `TCC_ADDR_CNT_HI) ||
                 (i_addr == `TCC_ADDR_ALT_HI)) begin
      rdata_reg <= cnt_reg[15:8];
    end else if ((i_addr == `TCC_ADDR_CNT_LO) ||
                 (i_addr == `TCC_ADDR_ALT_LO)) begin
      rdata_reg <= cnt_seq_reg ? cnt_buf_reg : cnt_reg[7:0];
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign o_rdata = rdata_reg;

endmodule : tcc_top
`default_nettype wire

// [tcc_checker.sv]
// port assertions for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tcc_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // interrupt and pins
  input wire logic i_cpu_mask,
  input wire logic o_timer_irq,
  input wire logic [1:0] o_compare_output_pin,
  input wire logic [1:0] o_compare_output_oe
);
  sequence s_lo_wr;
    i_wr && i_addr == 8'h0a;
  endsequence
  sequence s_lo_rd;
    i_rd && i_addr == 8'h0a;
  endsequence
  property p_rst_pin;
    @(posedge i_clk) i_rst |=> o_compare_output_pin == 2'h0;
  endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("compare pin not low after reset");
  property p_rst_oe;
    @(posedge i_clk) i_rst |=> o_compare_output_oe == 2'h0;
  endproperty
  a_rst_oe: assert property (p_rst_oe)
    else $error("pin driven after reset");
  property p_rst_irq;
    @(posedge i_clk) i_rst |=> !o_timer_irq && o_rdata == 8'h00;
  endproperty
  a_rst_irq: assert property (p_rst_irq)
    else $error("request or data left after reset");
  property p_mask;
    @(posedge i_clk) disable iff (i_rst) i_cpu_mask |-> !o_timer_irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("request while cpu mask set");
  // a disabled pin 0 may never move, match or force alike
  property p_frozen;
    @(posedge i_clk) disable iff (i_rst)
      !o_compare_output_oe[0] |=> $stable(o_compare_output_pin[0]);
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("pin moved while not enabled");
  property p_oe;
    @(posedge i_clk) disable iff (i_rst)
      i_wr && i_addr == 8'h01 |=> o_compare_output_oe == $past(i_wdata[7:6]);
  endproperty
  a_oe: assert property (p_oe)
    else $error("output enable not taken");
  property p_force;
    @(posedge i_clk) disable iff (i_rst)
      i_wr && i_addr == 8'h00 && i_wdata[3] && o_compare_output_oe[0]
      |=> o_compare_output_pin[0] == $past(i_wdata[0]);
  endproperty
  a_force: assert property (p_force)
    else $error("forced level not on pin");
  property p_cmp_rb;
    @(posedge i_clk) disable iff (i_rst)
      s_lo_wr ##2 s_lo_rd |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_cmp_rb: assert property (p_cmp_rb)
    else $error("compare byte read back wrong");
endmodule : tcc_checker
bind tcc_top tcc_checker u_chk (.i_clk(i_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .i_cpu_mask(i_cpu_mask), .o_timer_irq(o_timer_irq),
  .o_compare_output_pin(o_compare_output_pin),
  .o_compare_output_oe(o_compare_output_oe));
`default_nettype wire

// [tcc_pin_model.sv]
// capture pins and external clock source facing the unit
`timescale 1ns/1ps
`default_nettype none
module tcc_pin_model #(
  parameter int DELAY_NS = 7
) (
  // requests from the bench
  input wire logic [1:0] i_toggle,
  input wire logic i_ext_run,
  // pins toward the unit
  output logic [1:0] o_capture_pin,
  output logic o_ext_clk_pin
);
  initial begin
    o_capture_pin = 2'h0;
    o_ext_clk_pin = 1'b0;
  end
  // edges land off the cpu clock grid, channel two slower
  always @(posedge i_toggle[0])
    #(DELAY_NS) o_capture_pin[0] = ~o_capture_pin[0];
  always @(posedge i_toggle[1])
    #(DELAY_NS * 2) o_capture_pin[1] = ~o_capture_pin[1];
  // clock stands low between bursts; 83 ns period keeps over eight cpu clocks
  always begin
    wait (i_ext_run);
    #43 o_ext_clk_pin = 1'b1;
    #40 o_ext_clk_pin = 1'b0;
  end
endmodule : tcc_pin_model
`default_nettype wire

// [tcc_top_tb.sv]
// self-checking bench for the capture/compare unit
`timescale 1ns/1ps
`default_nettype none
module tcc_top_tb;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cpu_mask = 1'b0;
  logic [1:0] toggle = 2'h0;
  logic ext_run = 1'b0;
  logic [7:0] o_rdata;
  logic o_timer_irq;
  logic [1:0] cap_pin, pin, oe;
  logic ext_pin;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic rd_seen = 1'b0;
  logic [31:0] rng = 32'h00016d28; // seed 93480
  logic [15:0] v;
  int n;
  int errors = 0;
  int tests_run = 0;
  always #5 i_clk = ~i_clk;
  tcc_top uut (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_cpu_mask(i_cpu_mask), .o_timer_irq(o_timer_irq),
    .i_capture_pin(cap_pin), .i_ext_clk_pin(ext_pin),
    .o_compare_output_pin(pin), .o_compare_output_oe(oe));
  tcc_pin_model model (.i_toggle(toggle), .i_ext_run(ext_run),
    .o_capture_pin(cap_pin), .o_ext_clk_pin(ext_pin));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    tests_run++;
    if (seen !== expd) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, expd);
    end
  endtask : check
  task automatic print_verdict();
    $display("compared %0d, mismatched %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic cycles(input int k);
    repeat (k) @(posedge i_clk);
  endtask : cycles
  // one strobe cycle; a read notes expected byte and mask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e, input logic [7:0] m);
    @(posedge i_clk);
    i_wr <= w;
    i_rd <= !w;
    i_addr <= a;
    i_wdata <= d;
    if (!w) exp_q.push_back({e, m});
    @(posedge i_clk);
    i_wr <= 1'b0;
    i_rd <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'h00, 8'h00);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic [7:0] m);
    bus(1'b0, a, 8'h00, e, m);
  endtask : rd
  task automatic pulse(input logic [1:0] m);
    @(posedge i_clk);
    toggle <= m;
    cycles(2);
    toggle <= 2'h0;
    cycles(2);
  endtask : pulse
  task automatic irq_is(input logic e);
    #1;
    check({7'h00, o_timer_irq}, {7'h00, e});
  endtask : irq_is
  // read data stand only in the cycle after the strobe
  always @(posedge i_clk) begin
    rd_seen <= i_rd;
    if (rd_seen && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[7:0] != 8'h00) check(o_rdata & note[7:0], note[15:8] & note[7:0]);
    end
  end
  initial begin
    #50000;
    errors++;
    $display("mismatch at %0t: watchdog ran out", $time);
    print_verdict();
  end
  initial begin
    cycles(3);
    i_rst <= 1'b0;
    rd(8'h07, 8'h80, 8'hff);
    rd(8'h08, 8'h00, 8'hff);
    rd(8'h3f, 8'h00, 8'hff);
    rng = xorshift(rng);
    v = rng[15:0];
    wr(8'h09, v[15:8]);
    wr(8'h0a, v[7:0]);
    rd(8'h0a, v[7:0], 8'hff);
    rd(8'h09, v[15:8], 8'hff);
    wr(8'h03, v[7:0]);
    rd(8'h03, 8'h00, 8'hff);
    rd(8'h04, 8'h00, 8'hff);
    $display("register test done");
    wr(8'h01, 8'hcd);
    rd(8'h02, 8'h00, 8'h00);
    wr(8'h0c, 8'h00);
    cycles(20);
    rd(8'h02, 8'h00, 8'h08);
    rd(8'h0b, 8'hff, 8'hff);
    rd(8'h0c, 8'hfc, 8'hff);
    ext_run <= 1'b1;
    repeat (6) @(posedge ext_pin);
    ext_run <= 1'b0;
    cycles(10);
    rd(8'h0b, 8'h00, 8'hff);
    rd(8'h0c, 8'h02, 8'hff);
    rd(8'h02, 8'h08, 8'h08);
    $display("counter test done");
    wr(8'h01, 8'hc4);
    wr(8'h00, 8'h43);
    wr(8'h07, 8'h00);
    rd(8'h02, 8'h00, 8'h00);
    wr(8'h08, 8'h40);
    wr(8'h0c, 8'h00);
    n = 0;
    while (pin[0] !== 1'b1 && n < 300) begin
      @(posedge i_clk);
      n++;
    end
    #1;
    check({7'h00, pin[0]}, 8'h01);
    check({6'h00, oe}, 8'h03);
    irq_is(1'b1);
    @(posedge i_clk);
    i_cpu_mask <= 1'b1;
    irq_is(1'b0);
    rd(8'h02, 8'h10, 8'h10);
    rd(8'h08, 8'h40, 8'hff);
    rd(8'h02, 8'h00, 8'h10);
    i_cpu_mask <= 1'b0;
    wr(8'h00, 8'h08);
    #1;
    check({7'h00, pin[0]}, 8'h00);
    rd(8'h02, 8'h00, 8'h10);
    wr(8'h01, 8'h40);
    wr(8'h00, 8'h01);
    wr(8'h0c, 8'h00);
    n = 0;
    while (pin[0] !== 1'b1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    #1;
    check({7'h00, pin[0]}, 8'h01);
    rd(8'h0c, 8'h40, 8'hfc);
    $display("compare test done");
    wr(8'h01, 8'hc6);
    wr(8'h00, 8'h84);
    pulse(2'h3);
    cycles(8);
    irq_is(1'b1);
    rd(8'h02, 8'hc0, 8'hc0);
    rd(8'h04, 8'h00, 8'h00);
    rd(8'h06, 8'h00, 8'h00);
    rd(8'h02, 8'h00, 8'hc0);
    rd(8'h03, 8'h00, 8'h00);
    pulse(2'h1);
    pulse(2'h1);
    cycles(8);
    rd(8'h02, 8'h00, 8'h40);
    rd(8'h04, 8'h00, 8'h00);
    pulse(2'h1);
    pulse(2'h1);
    cycles(8);
    rd(8'h02, 8'h40, 8'h40);
    $display("capture test done");
    cycles(4);
    print_verdict();
  end
endmodule : tcc_top_tb
`default_nettype wire
